// ===== rtl/conv_section.v
// One conversion section: channel and config holding, start gating, timing and result
`timescale 1ns/1ps
`include "dual_adc_regs.vh"
module conv_section #(
    parameter CNT_W      = 8,
    parameter CONV_TICKS = `CONV_TICKS
) (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        wrChan,
    input  wire        wrCfg,
    input  wire [2:0]  chanIn,
    input  wire [2:0]  cfgIn,
    input  wire        divTick,
    input  wire [79:0] analogCode,
    output reg  [2:0]  muxSel,
    output reg  [1:0]  divCode,
    output reg         busy,
    output reg  [9:0]  result
);
    reg  [2:0]       chanHeld;
    reg              fmtBinary;
    reg              fmtActive;      // Format latched at start, safe from later writes
    reg              chanSet;
    reg              cfgSet;
    reg  [CNT_W-1:0] ticks;
    wire             chanNow;
    wire             cfgNow;
    wire             start;
    wire [9:0]       rawCode;

    assign chanNow = chanSet | wrChan;
    assign cfgNow  = cfgSet | wrCfg;
    // Start waits for both writes, in either order
    assign start   = chanNow && cfgNow && !busy;
    // Binary channel index of the running conversion selects one input
    assign rawCode = analogCode[muxSel*10 +: 10];

    // Register holding, start gating and conversion timing
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chanHeld  <= `CHAN_SEL_RESET;
            fmtBinary <= `FMT_BINARY_RESET;
            fmtActive <= `FMT_BINARY_RESET;
            divCode   <= `DIV_CODE_RESET;
            chanSet   <= 1'b0;
            cfgSet    <= 1'b0;
            busy      <= 1'b0;
            ticks     <= {CNT_W{1'b0}};
            muxSel    <= `CHAN_SEL_RESET;
            result    <= `RESULT_RESET;
        end else begin
            if (wrChan) begin
                chanHeld <= chanIn;
            end
            if (wrCfg) begin
                fmtBinary <= cfgIn[`FMT_SEL_BIT];
                divCode   <= cfgIn[`DIV_FIELD_MSB:`DIV_FIELD_LSB];
            end
            if (start) begin
                chanSet <= 1'b0;
                cfgSet  <= 1'b0;
                busy    <= 1'b1;
                ticks   <= {CNT_W{1'b0}};
                muxSel  <= wrChan ? chanIn : chanHeld;
                fmtActive <= wrCfg ? cfgIn[`FMT_SEL_BIT] : fmtBinary;
            end else begin
                chanSet <= chanNow;
                cfgSet  <= cfgNow;
                if (busy && divTick) begin
                    if (ticks == CONV_TICKS - 1) begin
                        busy   <= 1'b0;
                        // Linear code; two's complement flips the top bit
                        result <= fmtActive ? rawCode : (rawCode ^ `TWOS_FLIP);
                    end else begin
                        ticks <= ticks + 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ===== rtl/dual_adc_register_interface.v
// Register interface for two ten-bit conversion sections in narrow or wide bus layout
// Bus: busWr/busRd are single-cycle strobes on busAddr. Reads answer one
// cycle later with a one-cycle busRdValid and busRdData, the data held until the next read.
// Writes to write-only offsets never change read data.
`timescale 1ns/1ps
`include "dual_adc_regs.vh"
module dual_adc_register_interface #(
    parameter CONV_TICKS = `CONV_TICKS,
    parameter CNT_W      = 8
) (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        wideMode,
    input  wire [1:0]  busAddr,
    input  wire        busWr,
    input  wire        busRd,
    input  wire [15:0] busWrData,
    input  wire        srcTick,
    input  wire [79:0] analogCodeA,
    input  wire [79:0] analogCodeB,
    output reg  [15:0] busRdData,
    output reg         busRdValid,
    output wire [2:0]  muxSelA,
    output wire [2:0]  muxSelB,
    output wire [1:0]  convBusy,
    output wire        divTickA,
    output wire        divTickB
);
    // Per-section write strobes and field values
    reg  [1:0]  wrChan;
    reg  [1:0]  wrCfg;
    reg  [2:0]  chanIn [0:1];
    reg  [2:0]  cfgIn  [0:1];
    // Per-section outputs of the section logic
    wire [9:0]  result [0:1];
    wire [1:0]  divCode [0:1];
    wire [2:0]  muxSel [0:1];
    wire [1:0]  divTick;
    wire [79:0] analogCode [0:1];
    // Read data assembled before the output flop
    reg  [15:0] next_rdData;
    wire [7:0]  laneA;
    wire [7:0]  laneB;
    wire        narrowSecB;
    wire        narrowCfg;

    assign analogCode[0] = analogCodeA;
    assign analogCode[1] = analogCodeB;
    assign laneA         = busWrData[7:0];
    assign laneB         = busWrData[15:8];
    assign narrowSecB    = busAddr[1];
    assign narrowCfg     = busAddr[0];

    // Write decode: narrow layout addresses one section per byte pair,
    // wide layout writes both sections from the two byte lanes at once
    always @* begin
        wrChan    = 2'b00;
        wrCfg     = 2'b00;
        chanIn[0] = `CHAN_SEL_RESET;
        chanIn[1] = `CHAN_SEL_RESET;
        cfgIn[0]  = `CONV_CFG_RESET;
        cfgIn[1]  = `CONV_CFG_RESET;
        if (busWr) begin
            if (wideMode) begin
                // Section A from D2..D0, section B from D10..D8
                chanIn[0] = laneA[`CHAN_FIELD_MSB:`CHAN_FIELD_LSB];
                chanIn[1] = laneB[`CHAN_FIELD_MSB:`CHAN_FIELD_LSB];
                // Format and divider from D2..D0 and D10..D8
                cfgIn[0]  = laneA[2:0];
                cfgIn[1]  = laneB[2:0];
                if (busAddr[1] == `OFF_CHAN_SEL_WIDE >> 1) begin
                    wrChan = 2'b11;
                end else begin
                    wrCfg  = 2'b11;
                end
            end else begin
                // Only D2..D0 of the byte matter; D7..D3 ignored
                chanIn[narrowSecB] = laneA[`CHAN_FIELD_MSB:`CHAN_FIELD_LSB];
                cfgIn[narrowSecB]  = laneA[2:0];
                if (narrowCfg) begin
                    wrCfg[narrowSecB]  = 1'b1;
                end else begin
                    wrChan[narrowSecB] = 1'b1;
                end
            end
        end
    end

    // One divider and one conversion section per section letter
    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1) begin : gSection
            // Divides the source tick per the programmed code
            tick_divider uDiv (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .srcTick (srcTick),
                .divCode (divCode[s]),
                .divTick (divTick[s])
            );
            conv_section #(
                .CNT_W      (CNT_W),
                .CONV_TICKS (CONV_TICKS)
            ) uSec (
                .sys_clk    (sys_clk),
                .rst_n      (rst_n),
                .wrChan     (wrChan[s]),
                .wrCfg      (wrCfg[s]),
                .chanIn     (chanIn[s]),
                .cfgIn      (cfgIn[s]),
                .divTick    (divTick[s]),
                .analogCode (analogCode[s]),
                .muxSel     (muxSel[s]),
                .divCode    (divCode[s]),
                .busy       (convBusy[s]),
                .result     (result[s])
            );
        end
    endgenerate

    assign muxSelA  = muxSel[0];
    assign muxSelB  = muxSel[1];
    assign divTickA = divTick[0];
    assign divTickB = divTick[1];

    // Read mux: narrow layout returns one byte in the low lane, upper lane zero
    always @* begin
        next_rdData = 16'h0000;
        if (wideMode) begin
            if (busAddr[1] == `OFF_RESULT_LO_WIDE >> 1) begin
                // B bits 1,0 on D15,D14 and A bits 1,0 on D7,D6
                next_rdData = {result[1][1:0], 6'h00, result[0][1:0], 6'h00};
            end else begin
                // B bits 9..2 high byte A bits 9..2 low byte
                next_rdData = {result[1][9:2], result[0][9:2]};
            end
        end else begin
            if (narrowCfg) begin
                // High register: bits 9..2 on D7..D0
                next_rdData = {8'h00, result[narrowSecB][9:2]};
            end else begin
                // Low register: bits 1,0 on D7,D6, D5..D0 zero
                next_rdData = {8'h00, result[narrowSecB][1:0], 6'h00};
            end
        end
    end

    // Read answer registered one cycle after the strobe
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busRdData  <= 16'h0000;
            busRdValid <= 1'b0;
        end else begin
            busRdValid <= busRd;
            if (busRd) begin
                busRdData <= next_rdData;
            end
        end
    end
endmodule

// ===== rtl/dual_adc_regs.vh
// Register offsets, field positions and timing constants of the dual converter interface
`ifndef DUAL_ADC_REGS_VH
`define DUAL_ADC_REGS_VH

// Narrow layout: byte offsets inside the four-byte window
`define OFF_RESULT_LO_A   2'h0
`define OFF_RESULT_HI_A   2'h1
`define OFF_CHAN_SEL_A    2'h0
`define OFF_CONV_CFG_A    2'h1
`define OFF_RESULT_LO_B   2'h2
`define OFF_RESULT_HI_B   2'h3
`define OFF_CHAN_SEL_B    2'h2
`define OFF_CONV_CFG_B    2'h3

// Wide layout: word offsets (address bit 0 ignored)
`define OFF_RESULT_LO_WIDE 2'h0
`define OFF_CHAN_SEL_WIDE  2'h0
`define OFF_RESULT_HI_WIDE 2'h2
`define OFF_CONV_CFG_WIDE  2'h2

// Field positions inside a byte lane
`define CHAN_FIELD_MSB    2
`define CHAN_FIELD_LSB    0
`define FMT_SEL_BIT       2
`define DIV_FIELD_MSB     1
`define DIV_FIELD_LSB     0
`define LANE_B_LSB        8
`define RES_LO_BIT_POS    6

// Reset values
`define CHAN_SEL_RESET    3'h0
`define CONV_CFG_RESET    3'h7
`define FMT_BINARY_RESET  1'b1
`define DIV_CODE_RESET    2'h3
`define RESULT_RESET      10'h000

// Format: value xor'd into a straight-binary code to get two's complement
`define TWOS_FLIP         10'h200

// Conversion time in microseconds and converter clock after the divide-by-8
`define CONV_TIME_US      100
`define CONV_CLK_MHZ      1
`define CONV_TICKS        (`CONV_TIME_US * `CONV_CLK_MHZ)

`endif

// ===== rtl/tick_divider.v
// Divides the converter source tick by 1, 2, 4 or 8
`timescale 1ns/1ps
module tick_divider (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire       srcTick,
    input  wire [1:0] divCode,
    output reg        divTick
);
    reg  [2:0] count;
    wire [2:0] mask;

    // Code n keeps one source tick in 2**n
    assign mask = (3'h1 << divCode) - 3'h1;

    // Free-running source tick counter and divided tick
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= 3'h0;
            divTick <= 1'b0;
        end else begin
            divTick <= srcTick && ((count & mask) == mask);
            if (srcTick) begin
                count <= count + 3'h1;
            end
        end
    end
endmodule

// ===== sim/conv_clock_source.sv
// Converter clock source model: one-cycle tick per source period
`timescale 1ns/1ps
module conv_clock_source #(
    parameter int PERIOD = 6
) (
    input  logic sys_clk,
    input  logic rst_n,
    output logic srcTick
);
    logic [3:0] count;
    // Six system cycles stand in for one period of the 8 MHz source
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= 4'h0;
            srcTick <= 1'b0;
        end else begin
            count   <= (count == 4'(PERIOD - 1)) ? 4'h0 : count + 4'h1;
            srcTick <= (count == 4'(PERIOD - 1));
        end
    end
endmodule

// ===== sim/dual_adc_register_interface_asserts.sv
// Port-level checks of the dual converter register interface
`timescale 1ns/1ps
module dual_adc_register_interface_asserts (
    input logic        sys_clk,
    input logic        rst_n,
    input logic        wideMode,
    input logic [1:0]  busAddr,
    input logic        busWr,
    input logic        busRd,
    input logic        srcTick,
    input logic [15:0] busRdData,
    input logic        busRdValid,
    input logic [2:0]  muxSelA,
    input logic [1:0]  convBusy,
    input logic        divTickA
);
    // Bound above the longest conversion with a four-tick count at divide by eight
    localparam int BUSY_MAX = 300;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_RD_ANSWER: assert property (busRd |=> busRdValid)
        else $error("read not answered");
    AST_RD_ONLY: assert property (!busRd |=> !busRdValid)
        else $error("read data flagged without a read");
    AST_RD_HOLD: assert property (!busRdValid |-> $stable(busRdData))
        else $error("read data moved between reads");
    AST_NARROW_LO: assert property (busRdValid && !wideMode && !$past(busAddr[0])
        |-> busRdData[5:0] == 6'h00)
        else $error("narrow low register unused bits set");
    AST_WIDE_LO: assert property (busRdValid && wideMode && !$past(busAddr[1])
        |-> busRdData[13:8] == 6'h00 && busRdData[5:0] == 6'h00)
        else $error("wide low word unused bits set");
    AST_MUX_STEADY: assert property (convBusy[0] && $past(convBusy[0]) |-> $stable(muxSelA))
        else $error("channel moved during conversion");
    AST_BUSY_BOUND: assert property ($rose(convBusy[0]) |-> ##[1:BUSY_MAX] !convBusy[0])
        else $error("conversion did not finish");
    AST_START_CAUSE: assert property ($rose(convBusy[1])
        |-> $past(busWr) || $past(busWr, 2) || $past(convBusy[1], 2))
        else $error("conversion started without a write");
    AST_TICK_SRC: assert property (divTickA |-> $past(srcTick))
        else $error("divided tick without a source tick");
    // Main scenarios
    cover property ($fell(convBusy[0]));
    cover property ($rose(convBusy[1]));
    cover property (busRdValid && wideMode);
endmodule
bind dual_adc_register_interface dual_adc_register_interface_asserts chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .wideMode(wideMode), .busAddr(busAddr),
    .busWr(busWr), .busRd(busRd), .srcTick(srcTick), .busRdData(busRdData),
    .busRdValid(busRdValid), .muxSelA(muxSelA), .convBusy(convBusy), .divTickA(divTickA));

// ===== sim/dual_adc_register_interface_tb.sv
// Self-checking bench for the dual converter register interface
`timescale 1ns/1ps
module dual_adc_register_interface_tb;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wideMode = 1'b0;
    logic        busWr = 1'b0;
    logic        busRd = 1'b0;
    logic [1:0]  busAddr = 2'h0;
    logic [15:0] busWrData = 16'h0000;
    logic [79:0] analogCodeA, analogCodeB;
    logic [15:0] busRdData, rdVal;
    logic [2:0]  muxSelA, muxSelB;
    logic [1:0]  convBusy;
    logic        busRdValid, divTickA, divTickB, srcTick;
    logic [9:0]  codeA [0:7], codeB [0:7], eA, eB;
    int          err_count = 0, tests_run = 0, n, k;

    conv_clock_source src (.sys_clk(sys_clk), .rst_n(rst_n), .srcTick(srcTick));
    dual_adc_register_interface #(.CONV_TICKS(4)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .wideMode(wideMode), .busAddr(busAddr),
        .busWr(busWr), .busRd(busRd), .busWrData(busWrData), .srcTick(srcTick),
        .analogCodeA(analogCodeA), .analogCodeB(analogCodeB), .busRdData(busRdData),
        .busRdValid(busRdValid), .muxSelA(muxSelA), .muxSelB(muxSelB),
        .convBusy(convBusy), .divTickA(divTickA), .divTickB(divTickB));

    initial forever #10 sys_clk = ~sys_clk;

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        busAddr   <= a;
        busWrData <= d;
        busWr     <= 1'b1;
        @(posedge sys_clk);
        busWr <= 1'b0;
    endtask
    // Read data is taken in the cycle after the strobe
    task automatic rd(input logic [1:0] a);
        @(posedge sys_clk);
        busAddr <= a;
        busRd   <= 1'b1;
        @(posedge sys_clk);
        busRd <= 1'b0;
        #1;
        rdVal = busRdValid ? busRdData : 16'hxxxx;
    endtask
    task automatic waitIdle(input logic s);
        for (int i = 0; i < 400 && convBusy[s] !== 1'b0; i++) tick;
        chk({15'h0, convBusy[s]}, 16'h0);
    endtask
    task automatic waitConv(input logic s);
        for (int i = 0; i < 8 && convBusy[s] !== 1'b1; i++) tick;
        chk({15'h0, convBusy[s]}, 16'h1);
        waitIdle(s);
    endtask
    // Swap writes the config first and shows one write alone stays idle
    task automatic narrowConv(input logic s, input logic [7:0] ch, input logic [7:0] cfg,
                              input logic [9:0] exp, input logic swap);
        wr({s, swap}, {8'h00, swap ? cfg : ch});
        if (swap) begin
            repeat (20) tick;
            chk({15'h0, convBusy[s]}, 16'h0);
        end
        wr({s, ~swap}, {8'h00, swap ? ch : cfg});
        waitConv(s);
        rd({s, 1'b1});
        chk(rdVal, {8'h00, exp[9:2]});
        rd({s, 1'b0});
        chk(rdVal, {8'h00, exp[1:0], 6'h00});
    endtask
    // Source ticks between two divided ticks
    task automatic divGap(input logic s, output int c);
        c = 0;
        for (int i = 0; i < 80 && (s ? divTickB : divTickA) !== 1'b1; i++) tick;
        for (int i = 0; i < 80; i++) begin
            tick;
            if ((s ? divTickB : divTickA) === 1'b1) break;
            c += int'(srcTick);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        for (n = 0; n < 8; n++) begin
            codeA[n] = (n == 7) ? 10'h3ff : 10'(n * 146);
            codeB[n] = ~codeA[n];
            analogCodeA[n * 10 +: 10] <= codeA[n];
            analogCodeB[n * 10 +: 10] <= codeB[n];
        end
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (n = 0; n < 8; n++) begin
            narrowConv(1'b0, 8'(n), 8'h07, codeA[n], 1'b0);
            chk({13'h0, muxSelA}, 16'(n));
            narrowConv(1'b1, 8'(n), 8'h07, codeB[n], 1'b0);
            chk({13'h0, muxSelB}, 16'(n));
        end
        $display("test narrow channels done");
        narrowConv(1'b0, 8'h03, 8'h03, codeA[3] ^ 10'h200, 1'b0);
        narrowConv(1'b1, 8'h07, 8'h03, 10'h200, 1'b1);
        narrowConv(1'b1, 8'hfe, 8'hff, codeB[6], 1'b1);
        $display("test format and write order done");
        for (n = 0; n < 4; n++) begin
            wr(2'h1, 16'(4 + n));
            wr(2'h0, 16'h0000);
            divGap(1'b0, k);
            divGap(1'b0, k);
            chk(k[15:0], 16'(1 << n));
            waitIdle(1'b0);
        end
        divGap(1'b1, k);
        divGap(1'b1, k);
        chk(k[15:0], 16'h0008);
        $display("test divider codes done");
        @(posedge sys_clk);
        wideMode <= 1'b1;
        eA = codeA[2];
        eB = codeB[5] ^ 10'h200;
        wr(2'h0, 16'hfdfa);
        wr(2'h2, 16'hfbff);
        waitConv(1'b0);
        waitIdle(1'b1);
        chk({13'h0, muxSelB}, 16'h0005);
        rd(2'h2);
        chk(rdVal, {eB[9:2], eA[9:2]});
        rd(2'h0);
        chk(rdVal, {eB[1:0], 6'h00, eA[1:0], 6'h00});
        $display("test wide layout done");
        results;
    end

    // Watchdog sized well above the expected run length
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        results;
    end
endmodule
